// *** design/opsh_pkg.sv ***
// Shared constants and types for the operation status hierarchy.
// Assumes one 200 MHz clock and that every user of these names
// writes them with the package prefix.
package opsh_pkg;

    // ---------------------------------------------------------------
    // Register shape
    // ---------------------------------------------------------------
    localparam int unsigned REG_W        = 16;
    localparam logic [15:0] REG_RESET    = 16'h0000;
    localparam int unsigned SUB_USED_BIT = 1;     // Only used sub bit
    localparam int unsigned NUM_SUB      = 6;

    // Summary positions in the top operation register
    localparam int unsigned POS_CAL  = 0;
    localparam int unsigned POS_MEAS = 4;
    localparam int unsigned POS_TRIG = 5;
    localparam int unsigned POS_INIT = 10;
    localparam int unsigned POS_LOW  = 11;
    localparam int unsigned POS_HIGH = 12;

    // Index of each sub-register in the summary vector
    localparam int unsigned IDX_CAL  = 0;
    localparam int unsigned IDX_MEAS = 1;
    localparam int unsigned IDX_TRIG = 2;
    localparam int unsigned IDX_INIT = 3;
    localparam int unsigned IDX_LOW  = 4;
    localparam int unsigned IDX_HIGH = 5;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned INIT_TIME_NS  = 1000;  // Plain default
    localparam int unsigned INIT_CYCLES   =
        (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned INIT_CNT_W    = 8;
    localparam logic [7:0]  INIT_LAST     = 8'(INIT_CYCLES - 1);

    // ---------------------------------------------------------------
    // Query selection, one code per readable register
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_OPER_COND,
        SEL_OPER_EVENT,
        SEL_CAL_COND,
        SEL_CAL_EVENT,
        SEL_MEAS_COND,
        SEL_MEAS_EVENT,
        SEL_TRIG_COND,
        SEL_TRIG_EVENT,
        SEL_INIT_COND,
        SEL_INIT_EVENT,
        SEL_LOW_COND,
        SEL_LOW_EVENT,
        SEL_HIGH_COND,
        SEL_HIGH_EVENT
    } opsh_sel_e;

    typedef struct packed {
        logic      valid;
        opsh_sel_e sel;
    } opsh_query_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } opsh_answer_s;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] value;
    } opsh_sample_s;

endpackage : opsh_pkg

// *** design/opsh_sub_reg.sv ***
// One condition/event pair of the operation branch.
// Assumes clr is a one-cycle pulse from the query decoder.
module opsh_sub_reg (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic cond_in,
    input  wire logic level_mode,
    input  wire logic clr,
    output logic      cond_ff,
    output logic      event_ff
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic nxt_event;
    logic ev_set;

    // Edge mode catches start and end; level mode catches any dwell
    assign ev_set = level_mode ? cond_in : (cond_in ^ cond_ff);

    // Set wins over the read clear so a same-cycle event survives
    assign nxt_event = ev_set | (event_ff & ~clr);

    // Condition half follows the present state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cond_ff <= 1'b0;
        end else if (ce) begin
            cond_ff <= cond_in;
        end
    end

    // Event half records occurrences since the last read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_ff <= 1'b0;
        end else if (ce) begin
            event_ff <= nxt_event;
        end
    end

endmodule : opsh_sub_reg

// *** design/opsh_status.sv ***
// Operation status hierarchy: top operation register, six sub
// registers, the activity trackers that feed them and a query port.
// Assumes all inputs are synchronous to clk and pulses last one cycle.

// Behaviour
// - Calibrating summary drives top bit 0
// - Measuring summary drives top bit 4
// - Trigger-wait summary drives top bit 5
// - Initialization summary drives top bit 10
// - Below-limit summary drives top bit 11
// - Above-limit summary drives top bit 12
// - Every register has condition and event halves
// - Calibrating condition bit 1 while calibrating
// - Calibration start or end latches until read
// - Measuring condition bit 1 while measuring
// - Measurement start or end latches until read
// - Waiting bit 1; trigger moves to measuring
// - Trigger event records any waiting time
// - Initialization condition bit 1 while initializing
// - Initialize on power-up, connect, reset, preset
// - Initialization start or end latches until read
// - Below-limit condition while value under limit
// - Below-limit event latches any low value
// - Above-limit condition while value over limit
// - Above-limit event latches any high value
module opsh_status (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    input  wire logic                    host_connect,
    input  wire logic                    reset_cmd,
    input  wire logic                    preset_cmd,
    input  wire logic                    cal_start,
    input  wire logic                    cal_done,
    input  wire logic                    meas_arm,
    input  wire logic                    trig_in,
    input  wire opsh_pkg::opsh_sample_s  sample,
    input  wire logic signed [15:0]      lower_limit,
    input  wire logic signed [15:0]      upper_limit,
    input  wire opsh_pkg::opsh_query_s   query,
    output opsh_pkg::opsh_answer_s       answer_ff,
    output logic [15:0]                  oper_cond_ff
);

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Place one sub bit at its used position, rest zero
    function automatic logic [15:0] sub_word(input logic b);
        logic [15:0] w;
        w = opsh_pkg::REG_RESET;
        w[opsh_pkg::SUB_USED_BIT] = b;
        return w;
    endfunction : sub_word

    // Spread the six summaries over the top register
    function automatic logic [15:0] place(input logic [5:0] s);
        logic [15:0] w;
        w = opsh_pkg::REG_RESET;
        w[opsh_pkg::POS_CAL]  = s[opsh_pkg::IDX_CAL];
        w[opsh_pkg::POS_MEAS] = s[opsh_pkg::IDX_MEAS];
        w[opsh_pkg::POS_TRIG] = s[opsh_pkg::IDX_TRIG];
        w[opsh_pkg::POS_INIT] = s[opsh_pkg::IDX_INIT];
        w[opsh_pkg::POS_LOW]  = s[opsh_pkg::IDX_LOW];
        w[opsh_pkg::POS_HIGH] = s[opsh_pkg::IDX_HIGH];
        return w;
    endfunction : place

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    typedef enum logic [0:0] {
        INIT_IDLE,
        INIT_RUN
    } opsh_init_e;

    typedef enum logic [1:0] {
        MS_IDLE,
        MS_WAIT,
        MS_MEAS
    } opsh_meas_e;

    opsh_init_e         init_state_ff;
    opsh_init_e         nxt_init_state;
    logic [7:0]         init_cnt_ff;
    logic               power_up_ff;
    logic               init_req;
    opsh_meas_e         meas_state_ff;
    opsh_meas_e         nxt_meas_state;
    logic               cal_busy_ff;
    logic signed [15:0] value_ff;
    logic               value_ok_ff;
    logic               below_now;
    logic               above_now;
    logic [5:0]         act;
    logic [5:0]         level_mode;
    logic [5:0]         clr;
    logic [5:0]         sub_cond;
    logic [5:0]         sub_event;
    logic [15:0]        oper_event_ff;
    logic [15:0]        nxt_oper_event;
    logic [15:0]        summary_word;
    logic               take;
    logic [15:0]        nxt_data;

    assign take = ce & query.valid;

    // ---------------------------------------------------------------
    // Initialization tracker
    // ---------------------------------------------------------------

    // Power-up counts as a request on the first enabled cycle
    assign init_req = power_up_ff | host_connect
                    | reset_cmd | preset_cmd;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            power_up_ff <= 1'b1;
        end else if (ce) begin
            power_up_ff <= 1'b0;
        end
    end

    // A new request during a run restarts the count
    always_comb begin
        nxt_init_state = init_state_ff;
        case (init_state_ff)
            INIT_IDLE: begin
                if (init_req) begin
                    nxt_init_state = INIT_RUN;
                end
            end
            INIT_RUN: begin
                if (!init_req && init_cnt_ff == opsh_pkg::INIT_LAST) begin
                    nxt_init_state = INIT_IDLE;
                end
            end
            default: begin
                nxt_init_state = INIT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            init_state_ff <= INIT_IDLE;
        end else if (ce) begin
            init_state_ff <= nxt_init_state;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            init_cnt_ff <= 8'h00;
        end else if (ce) begin
            if (init_req || init_state_ff != INIT_RUN) begin
                init_cnt_ff <= 8'h00;
            end else begin
                init_cnt_ff <= init_cnt_ff + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // Calibration tracker
    // ---------------------------------------------------------------

    // Initialization aborts a calibration in progress
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cal_busy_ff <= 1'b0;
        end else if (ce) begin
            if (init_req || cal_done) begin
                cal_busy_ff <= 1'b0;
            end else if (cal_start) begin
                cal_busy_ff <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Measurement sequencer
    // ---------------------------------------------------------------

    // Arming is refused while calibrating or initializing
    always_comb begin
        nxt_meas_state = meas_state_ff;
        case (meas_state_ff)
            MS_IDLE: begin
                if (meas_arm && !cal_busy_ff
                    && init_state_ff == INIT_IDLE) begin
                    nxt_meas_state = MS_WAIT;
                end
            end
            MS_WAIT: begin
                if (trig_in) begin
                    nxt_meas_state = MS_MEAS;
                end
            end
            MS_MEAS: begin
                if (sample.valid) begin
                    nxt_meas_state = MS_IDLE;
                end
            end
            default: begin
                nxt_meas_state = MS_IDLE;
            end
        endcase
        if (init_req) begin
            nxt_meas_state = MS_IDLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meas_state_ff <= MS_IDLE;
        end else if (ce) begin
            meas_state_ff <= nxt_meas_state;
        end
    end

    // ---------------------------------------------------------------
    // Limit check
    // ---------------------------------------------------------------

    // Last result is held; no result yet means no limit failure
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            value_ff    <= 16'sh0000;
            value_ok_ff <= 1'b0;
        end else if (ce) begin
            if (init_req) begin
                value_ok_ff <= 1'b0;
            end else if (sample.valid) begin
                value_ff    <= sample.value;
                value_ok_ff <= 1'b1;
            end
        end
    end

    // Compared live so a limit change takes effect at once
    assign below_now = value_ok_ff && (value_ff < lower_limit);
    assign above_now = value_ok_ff && (value_ff > upper_limit);

    // ---------------------------------------------------------------
    // Sub-registers
    // ---------------------------------------------------------------
    assign act[opsh_pkg::IDX_CAL]  = cal_busy_ff;
    assign act[opsh_pkg::IDX_MEAS] = meas_state_ff == MS_MEAS;
    assign act[opsh_pkg::IDX_TRIG] = meas_state_ff == MS_WAIT;
    assign act[opsh_pkg::IDX_INIT] = init_state_ff == INIT_RUN;
    assign act[opsh_pkg::IDX_LOW]  = below_now;
    assign act[opsh_pkg::IDX_HIGH] = above_now;

    // Start/end groups use edges, dwell groups use levels
    assign level_mode[opsh_pkg::IDX_CAL]  = 1'b0;
    assign level_mode[opsh_pkg::IDX_MEAS] = 1'b0;
    assign level_mode[opsh_pkg::IDX_TRIG] = 1'b1;
    assign level_mode[opsh_pkg::IDX_INIT] = 1'b0;
    assign level_mode[opsh_pkg::IDX_LOW]  = 1'b1;
    assign level_mode[opsh_pkg::IDX_HIGH] = 1'b1;

    // Read of an event half clears it on the taking edge
    always_comb begin
        clr = 6'h00;
        if (take) begin
            case (query.sel)
                opsh_pkg::SEL_CAL_EVENT:  clr[opsh_pkg::IDX_CAL]  = 1'b1;
                opsh_pkg::SEL_MEAS_EVENT: clr[opsh_pkg::IDX_MEAS] = 1'b1;
                opsh_pkg::SEL_TRIG_EVENT: clr[opsh_pkg::IDX_TRIG] = 1'b1;
                opsh_pkg::SEL_INIT_EVENT: clr[opsh_pkg::IDX_INIT] = 1'b1;
                opsh_pkg::SEL_LOW_EVENT:  clr[opsh_pkg::IDX_LOW]  = 1'b1;
                opsh_pkg::SEL_HIGH_EVENT: clr[opsh_pkg::IDX_HIGH] = 1'b1;
                default:                  clr = 6'h00;
            endcase
        end
    end

    for (genvar g = 0; g < opsh_pkg::NUM_SUB; g++) begin : g_sub
        opsh_sub_reg u_sub (
            .clk        (clk),
            .nrst       (nrst),
            .ce         (ce),
            .cond_in    (act[g]),
            .level_mode (level_mode[g]),
            .clr        (clr[g]),
            .cond_ff    (sub_cond[g]),
            .event_ff   (sub_event[g])
        );
    end

    // ---------------------------------------------------------------
    // Top operation register
    // ---------------------------------------------------------------

    // Summary is the OR of the single used event bit
    assign summary_word = place(sub_event);

    // Top condition tracks the summaries as they stand
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oper_cond_ff <= opsh_pkg::REG_RESET;
        end else if (ce) begin
            oper_cond_ff <= summary_word;
        end
    end

    // Rising summaries set the top event; set beats the read clear
    always_comb begin
        nxt_oper_event = oper_event_ff;
        if (take && query.sel == opsh_pkg::SEL_OPER_EVENT) begin
            nxt_oper_event = opsh_pkg::REG_RESET;
        end
        nxt_oper_event = nxt_oper_event
                       | (summary_word & ~oper_cond_ff);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oper_event_ff <= opsh_pkg::REG_RESET;
        end else if (ce) begin
            oper_event_ff <= nxt_oper_event;
        end
    end

    // ---------------------------------------------------------------
    // Query answer
    // ---------------------------------------------------------------

    // Content is returned as it stood before the clearing edge
    always_comb begin
        case (query.sel)
            opsh_pkg::SEL_OPER_COND:  nxt_data = oper_cond_ff;
            opsh_pkg::SEL_OPER_EVENT: nxt_data = oper_event_ff;
            opsh_pkg::SEL_CAL_COND:
                nxt_data = sub_word(sub_cond[opsh_pkg::IDX_CAL]);
            opsh_pkg::SEL_CAL_EVENT:
                nxt_data = sub_word(sub_event[opsh_pkg::IDX_CAL]);
            opsh_pkg::SEL_MEAS_COND:
                nxt_data = sub_word(sub_cond[opsh_pkg::IDX_MEAS]);
            opsh_pkg::SEL_MEAS_EVENT:
                nxt_data = sub_word(sub_event[opsh_pkg::IDX_MEAS]);
            opsh_pkg::SEL_TRIG_COND:
                nxt_data = sub_word(sub_cond[opsh_pkg::IDX_TRIG]);
            opsh_pkg::SEL_TRIG_EVENT:
                nxt_data = sub_word(sub_event[opsh_pkg::IDX_TRIG]);
            opsh_pkg::SEL_INIT_COND:
                nxt_data = sub_word(sub_cond[opsh_pkg::IDX_INIT]);
            opsh_pkg::SEL_INIT_EVENT:
                nxt_data = sub_word(sub_event[opsh_pkg::IDX_INIT]);
            opsh_pkg::SEL_LOW_COND:
                nxt_data = sub_word(sub_cond[opsh_pkg::IDX_LOW]);
            opsh_pkg::SEL_LOW_EVENT:
                nxt_data = sub_word(sub_event[opsh_pkg::IDX_LOW]);
            opsh_pkg::SEL_HIGH_COND:
                nxt_data = sub_word(sub_cond[opsh_pkg::IDX_HIGH]);
            opsh_pkg::SEL_HIGH_EVENT:
                nxt_data = sub_word(sub_event[opsh_pkg::IDX_HIGH]);
            default:                  nxt_data = opsh_pkg::REG_RESET;
        endcase
    end

    // One-cycle answer; data holds until the next query
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            answer_ff <= '0;
        end else if (ce) begin
            answer_ff.valid <= query.valid;
            if (query.valid) begin
                answer_ff.data <= nxt_data;
            end
        end
    end

endmodule : opsh_status

// *** sim/opsh_status_monitor.sv ***
// Concurrent checks on the ports of the operation status hierarchy.
// Assumes one clock domain with asynchronous active-low reset.
module opsh_status_monitor (
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire logic                   ce,
    input wire logic                   host_connect,
    input wire logic                   reset_cmd,
    input wire logic                   preset_cmd,
    input wire logic                   cal_start,
    input wire logic                   meas_arm,
    input wire opsh_pkg::opsh_sample_s sample,
    input wire logic signed [15:0]     lower_limit,
    input wire logic signed [15:0]     upper_limit,
    input wire opsh_pkg::opsh_query_s  query,
    input wire opsh_pkg::opsh_answer_s answer_ff,
    input wire logic [15:0]            oper_cond_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------
    // Query handshake
    // ------------------------------
    // A query is answered on the very next cycle and never otherwise
    sequence s_taken;
        ce && query.valid;
    endsequence
    sequence s_answered;
        answer_ff.valid;
    endsequence
    a_answer_one_late: assert property (s_taken |=> s_answered)
        else $error("answer missing");
    a_answer_only_taken: assert property (
        answer_ff.valid |-> $past(query.valid) && $past(ce))
        else $error("stray answer");
    a_oper_cond_echo: assert property (
        s_taken and query.sel == opsh_pkg::SEL_OPER_COND
        |=> answer_ff.data == $past(oper_cond_ff))
        else $error("oper cond answer wrong");

    // ------------------------------
    // Unused bits
    // ------------------------------
    // Only the six summary positions, and bit 1 of a sub register, may ever be set
    a_oper_unused_zero: assert property (
        (oper_cond_ff & ~16'h1C31) == 16'h0000)
        else $error("oper unused bit set");
    a_sub_unused_zero: assert property (
        answer_ff.valid && $past(query.sel) != opsh_pkg::SEL_OPER_COND
        && $past(query.sel) != opsh_pkg::SEL_OPER_EVENT
        |-> answer_ff.data[15:2] == 14'h0000 && !answer_ff.data[0])
        else $error("sub unused bit set");

    // ------------------------------
    // Summaries reach the top register in bounded time
    // ------------------------------
    // Bound covers tracker, sub register and top register stages
    a_cal_summary: assert property (
        ce && cal_start |-> ##[1:5] oper_cond_ff[0])
        else $error("cal summary late");
    a_wait_summary: assert property (
        ce && meas_arm |-> ##[1:5] oper_cond_ff[5])
        else $error("wait summary late");
    a_init_summary: assert property (
        ce && (host_connect || reset_cmd || preset_cmd)
        |-> ##[1:5] oper_cond_ff[10])
        else $error("init summary late");
    a_low_summary: assert property (
        ce && sample.valid && sample.value < lower_limit
        |-> ##[1:5] oper_cond_ff[11])
        else $error("low summary late");
    a_high_summary: assert property (
        ce && sample.valid && sample.value > upper_limit
        |-> ##[1:5] oper_cond_ff[12])
        else $error("high summary late");
endmodule : opsh_status_monitor

bind opsh_status opsh_status_monitor u_mon (
    .clk(clk), .nrst(nrst), .ce(ce), .host_connect(host_connect),
    .reset_cmd(reset_cmd), .preset_cmd(preset_cmd),
    .cal_start(cal_start), .meas_arm(meas_arm), .sample(sample),
    .lower_limit(lower_limit), .upper_limit(upper_limit),
    .query(query), .answer_ff(answer_ff), .oper_cond_ff(oper_cond_ff)
);

// *** sim/tb_operation_status_hierarchy.sv ***
// Self-checking bench for the operation status hierarchy.
// Assumes the design package is compiled first; ce stays high.
module tb_operation_status_hierarchy;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk, nrst, ce, host_connect, reset_cmd;
    logic                   preset_cmd, cal_start, cal_done;
    logic                   meas_arm, trig_in;
    opsh_pkg::opsh_sample_s sample;
    logic signed [15:0]     lower_limit, upper_limit;
    opsh_pkg::opsh_query_s  query;
    opsh_pkg::opsh_answer_s answer_ff;
    logic [15:0]            oper_cond_ff;
    int                     err_count, comparisons;

    opsh_status dut (
        .clk(clk), .nrst(nrst), .ce(ce), .host_connect(host_connect),
        .reset_cmd(reset_cmd), .preset_cmd(preset_cmd),
        .cal_start(cal_start), .cal_done(cal_done),
        .meas_arm(meas_arm), .trig_in(trig_in), .sample(sample),
        .lower_limit(lower_limit), .upper_limit(upper_limit),
        .query(query), .answer_ff(answer_ff),
        .oper_cond_ff(oper_cond_ff)
    );

    // ------------------------------
    // Clock and watchdog
    // ------------------------------
    always #2.5 clk = ~clk;

    // A hang counts as a mismatch and still reaches the verdict
    initial begin
        #50000;
        err_count++;
        final_report();
    end

    // ------------------------------
    // Helpers
    // ------------------------------
    task chk(input string name, input logic [15:0] seen,
             input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task final_report;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // Top condition bit b must stand
    task obit(input int b);
        chk($sformatf("oper bit %0d", b), 16'(oper_cond_ff[b]), 16'h0001);
    endtask : obit

    // One-cycle pulse: 0 cal start, 1 cal done, 2 arm, 3 trigger,
    // 4 connect, 5 reset command, 6 preset command
    task pulse(input int k);
        @(posedge clk);
        case (k)
            0: cal_start <= 1'b1;
            1: cal_done <= 1'b1;
            2: meas_arm <= 1'b1;
            3: trig_in <= 1'b1;
            4: host_connect <= 1'b1;
            5: reset_cmd <= 1'b1;
            default: preset_cmd <= 1'b1;
        endcase
        @(posedge clk);
        {cal_start, cal_done, meas_arm, trig_in} <= 4'h0;
        {host_connect, reset_cmd, preset_cmd} <= 3'h0;
    endtask : pulse

    // Query is taken at the second edge; the answer stands one cycle
    task rd(input opsh_pkg::opsh_sel_e sel, input logic [15:0] exp);
        @(posedge clk);
        query <= '{valid: 1'b1, sel: sel};
        @(posedge clk);
        query.valid <= 1'b0;
        #1;
        chk("answer valid", 16'(answer_ff.valid), 16'h0001);
        chk(sel.name(), answer_ff.data, exp);
    endtask : rd

    // Arm, trigger and deliver one result, all in legal order
    task run_meas(input logic signed [15:0] v);
        pulse(2);
        tick(2);
        pulse(3);
        tick(2);
        @(posedge clk);
        sample <= '{valid: 1'b1, value: v};
        @(posedge clk);
        sample.valid <= 1'b0;
        tick(3);
    endtask : run_meas

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        ce = 1'b1;
        {host_connect, reset_cmd, preset_cmd} = 3'h0;
        {cal_start, cal_done, meas_arm, trig_in} = 4'h0;
        sample = '{valid: 1'b0, value: 16'h0000};
        lower_limit = -16'sd100;
        upper_limit = 16'sd100;
        query = '{valid: 1'b0, sel: opsh_pkg::SEL_OPER_COND};
        err_count = 0;
        comparisons = 0;
        tick(6);
        chk("oper in reset", oper_cond_ff, 16'h0000);
        nrst <= 1'b1;
        tick(3);
        rd(opsh_pkg::SEL_INIT_COND, 16'h0002);
        rd(opsh_pkg::SEL_INIT_EVENT, 16'h0002);
        tick(210);
        rd(opsh_pkg::SEL_INIT_COND, 16'h0000);
        rd(opsh_pkg::SEL_INIT_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_INIT_EVENT, 16'h0000);
        rd(opsh_pkg::SEL_OPER_COND, 16'h0000);
        rd(opsh_pkg::SEL_OPER_EVENT, 16'h0400);
        rd(opsh_pkg::SEL_OPER_EVENT, 16'h0000);
        // Connect, reset command and preset command each initialize
        for (int k = 4; k <= 6; k++) begin
            pulse(k);
            tick(3);
            rd(opsh_pkg::SEL_INIT_COND, 16'h0002);
            obit(10);
            tick(205);
            rd(opsh_pkg::SEL_INIT_EVENT, 16'h0002);
            rd(opsh_pkg::SEL_INIT_COND, 16'h0000);
        end
        // Calibration start and end both latch
        pulse(0);
        tick(3);
        rd(opsh_pkg::SEL_CAL_COND, 16'h0002);
        obit(0);
        rd(opsh_pkg::SEL_CAL_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_CAL_EVENT, 16'h0000);
        pulse(1);
        tick(3);
        rd(opsh_pkg::SEL_CAL_COND, 16'h0000);
        rd(opsh_pkg::SEL_CAL_EVENT, 16'h0002);
        // Wait for trigger, then measuring, then result in range
        pulse(2);
        tick(3);
        rd(opsh_pkg::SEL_TRIG_COND, 16'h0002);
        obit(5);
        rd(opsh_pkg::SEL_MEAS_COND, 16'h0000);
        pulse(3);
        tick(3);
        rd(opsh_pkg::SEL_TRIG_COND, 16'h0000);
        rd(opsh_pkg::SEL_MEAS_COND, 16'h0002);
        obit(4);
        rd(opsh_pkg::SEL_TRIG_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_TRIG_EVENT, 16'h0000);
        rd(opsh_pkg::SEL_MEAS_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_MEAS_EVENT, 16'h0000);
        @(posedge clk);
        sample <= '{valid: 1'b1, value: 16'h0000};
        @(posedge clk);
        sample.valid <= 1'b0;
        tick(3);
        rd(opsh_pkg::SEL_MEAS_COND, 16'h0000);
        rd(opsh_pkg::SEL_MEAS_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_LOW_COND, 16'h0000);
        rd(opsh_pkg::SEL_HIGH_COND, 16'h0000);
        // Results below, above, then exactly on a limit
        run_meas(-16'sd200);
        rd(opsh_pkg::SEL_LOW_COND, 16'h0002);
        rd(opsh_pkg::SEL_HIGH_COND, 16'h0000);
        obit(11);
        rd(opsh_pkg::SEL_LOW_EVENT, 16'h0002);
        run_meas(16'sd300);
        rd(opsh_pkg::SEL_LOW_COND, 16'h0000);
        rd(opsh_pkg::SEL_HIGH_COND, 16'h0002);
        obit(12);
        rd(opsh_pkg::SEL_HIGH_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_LOW_EVENT, 16'h0002);
        rd(opsh_pkg::SEL_LOW_EVENT, 16'h0000);
        @(posedge clk);
        upper_limit <= 16'sd400;
        tick(3);
        rd(opsh_pkg::SEL_HIGH_COND, 16'h0000);
        run_meas(16'sd400);
        rd(opsh_pkg::SEL_HIGH_COND, 16'h0000);
        rd(opsh_pkg::SEL_LOW_COND, 16'h0000);
        rd(opsh_pkg::opsh_sel_e'(4'hE), 16'h0000);
        final_report();
    end
endmodule : tb_operation_status_hierarchy
